/* File: include/pfs_pkg.sv */
// Purpose: constants, types and command map of the fault supervisor
// Assumes: 25 MHz ref_clk, 16-bit limit and measurement codes
// Notes:   current codes are 16 LSB per ampere
package pfs_pkg;

   localparam int CLK_HZ       = 25_000_000;
   localparam int CLK_NS       = 40;
   localparam int MS_CYCLES    = CLK_HZ / 1000;
   localparam logic [15:0] BOOT_MS   = 16'h000A;
   localparam logic [15:0] PIN_MS    = 16'h00C8;
   localparam logic [15:0] HICCUP_MS = 16'h0064;
   localparam logic [15:0] IOUT_PER_A = 16'h0010;
   localparam logic [15:0] OC_MAX_A   = 16'h0032;
   localparam logic [15:0] OC_MAX     = 16'(OC_MAX_A * IOUT_PER_A);

   localparam int NCFG = 16;
   localparam int I_NOM   = 0;
   localparam int I_OV    = 1;
   localparam int I_OC    = 2;
   localparam int I_OCW   = 3;
   localparam int I_OT    = 4;
   localparam int I_VINOV = 5;
   localparam int I_VINUV = 6;
   localparam int I_TON   = 7;
   localparam int I_TRISE = 8;
   localparam int I_OTHYS = 9;
   localparam int I_VINON = 10;
   localparam int I_OPER  = 11;
   localparam int I_ONOFF = 12;
   localparam int I_PGPOL = 13;
   localparam int I_PRI   = 14;
   localparam int I_OVRSP = 15;

   localparam logic [15:0] NOM_RST = 16'h3000;
   // overvoltage default sits 20 percent above nominal
   localparam logic [15:0] OV_RST  = NOM_RST + NOM_RST / 16'h0005;

   localparam logic [7:0] CFG_CODE [NCFG] = '{
      8'h21, 8'h40, 8'h46, 8'h4A, 8'h4F, 8'h55, 8'h59, 8'h60,
      8'h61, 8'hEA, 8'h35, 8'h01, 8'h02, 8'hD0, 8'hDD, 8'h41};
   localparam logic [15:0] CFG_RST [NCFG] = '{
      NOM_RST, OV_RST, 16'h0280, 16'h0200, 16'h007D, 16'h0050,
      16'h0020, 16'h0000, 16'h001E, 16'h000A, 16'h0022, 16'h0080,
      16'h0000, 16'h0000, 16'h0000, 16'h0000};

   localparam logic [7:0] CLR_CODE    = 8'h03;
   localparam logic [7:0] STATUS_CODE = 8'h79;

   // field positions
   localparam int OPER_ON    = 7;
   localparam int SEC_USE    = 0;
   localparam int SEC_ON     = 1;
   localparam int PRI_IGNORE = 0;
   localparam int PRI_POS    = 1;
   localparam int OVRSP_LATCH = 0;

   // status word bits
   localparam int ST_VOUT_OV = 0;
   localparam int ST_IOUT_OC = 1;
   localparam int ST_IOUT_W  = 2;
   localparam int ST_VIN_UV  = 3;
   localparam int ST_VIN_OV  = 4;
   localparam int ST_OTEMP   = 5;
   localparam int ST_PG_FAIL = 6;
   localparam int NSTICKY    = 7;
   localparam int ST_OFF     = 8;
   localparam int ST_IN_REG  = 11;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } pfs_cmd_s;

   typedef struct packed {
      logic [15:0] vout;
      logic [15:0] iout;
      logic [15:0] vin;
      logic [15:0] temp;
   } pfs_meas_s;

   // nine states need four bits
   typedef enum logic [3:0] {
      S_INIT, S_BOOT, S_OFF, S_TON, S_RAMP, S_ON, S_OVW, S_HIC, S_OT
   } pfs_state_e;

endpackage

/* File: logic/pfs_ms_timer.sv */
// Purpose: millisecond countdown shared by the sequencing delays
// Assumes: start is a one-cycle pulse, restarts on a new start
// Notes:   done pulses once, one cycle after the last millisecond
module pfs_ms_timer #(
   parameter int MS_CYCLES = pfs_pkg::MS_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        start,
   input  wire logic [15:0] ms,
   output logic             done
);

   initial begin
      if (MS_CYCLES < 1 || MS_CYCLES > 65535)
         $error("MS_CYCLES out of range");
   end

   logic [15:0] pre_reg;
   logic [15:0] left_reg;
   logic        busy_reg;
   logic        done_reg;
   wire         wrap = (pre_reg == 16'(MS_CYCLES - 1));

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_reg  <= 16'h0000;
         left_reg <= 16'h0000;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (start) begin
         pre_reg  <= 16'h0000;
         left_reg <= ms;
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
      end else begin
         done_reg <= busy_reg && left_reg == 16'h0000;
         if (busy_reg && left_reg == 16'h0000)
            busy_reg <= 1'b0;
         pre_reg <= (wrap || !busy_reg) ? 16'h0000 : pre_reg + 16'h0001;
         if (busy_reg && wrap && left_reg != 16'h0000)
            left_reg <= left_reg - 16'h0001;
      end
   end

   assign done = done_reg;

endmodule

/* File: logic/pfs_supervisor.sv */
// Purpose: fault supervision and start-up sequencing of a power module
// Assumes: cmd comes decoded from the management bus layer, same clock
// Notes:   measurements and the on/off pin arrive unsynchronised
module pfs_supervisor #(
   parameter int MS_CYCLES = pfs_pkg::MS_CYCLES
) (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  pfs_pkg::pfs_cmd_s      cmd,
   input  pfs_pkg::pfs_meas_s     meas_raw,
   input  wire logic              on_off_pin,
   output logic                   rsp_valid,
   output logic [15:0]            rsp_rdata,
   output logic                   alert_n,
   output logic                   good_pin,
   output logic                   regulate_en,
   output logic                   softstart_active
);

   // two flops on everything from the pins or the analog side
   pfs_pkg::pfs_meas_s meas_s1_reg;
   pfs_pkg::pfs_meas_s m;
   logic               pin_s1_reg;
   logic               pin_s2_reg;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meas_s1_reg <= '0;
         m           <= '0;
         pin_s1_reg  <= 1'b1;
         pin_s2_reg  <= 1'b1;
      end else begin
         meas_s1_reg <= meas_raw;
         m           <= meas_s1_reg;
         pin_s1_reg  <= on_off_pin;
         pin_s2_reg  <= pin_s1_reg;
      end
   end

   // configuration registers
   logic [15:0] cfg_reg [pfs_pkg::NCFG];
   logic [15:0] rd_cfg  [pfs_pkg::NCFG];
   logic [pfs_pkg::NCFG-1:0] rd_hit;
   wire         wr_cmd = cmd.valid && cmd.write;
   wire         rd_cmd = cmd.valid && !cmd.write;

   // over-limit current values are refused, the old limit stays
   wire         oc_ok = cmd.wdata <= pfs_pkg::OC_MAX;

   genvar gi;
   generate
      for (gi = 0; gi < pfs_pkg::NCFG; gi++) begin : g_cfg
         wire hit = cmd.code == pfs_pkg::CFG_CODE[gi];
         wire ok  = (gi != pfs_pkg::I_OC) || oc_ok;
         assign rd_hit[gi] = hit;
         assign rd_cfg[gi] = hit ? cfg_reg[gi] : 16'h0000;
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n)
               cfg_reg[gi] <= pfs_pkg::CFG_RST[gi];
            else if (wr_cmd && hit && ok)
               cfg_reg[gi] <= cmd.wdata;
         end
      end
   endgenerate

   // fault and warning conditions
   wire [15:0] nom  = cfg_reg[pfs_pkg::I_NOM];
   wire [15:0] tol  = {3'b000, nom[15:3]};
   wire [15:0] othy = cfg_reg[pfs_pkg::I_OTHYS];
   wire [15:0] otl  = cfg_reg[pfs_pkg::I_OT];
   wire [15:0] ot_thr = (othy > otl) ? 16'h0000 : otl - othy;
   wire ov_c   = m.vout > cfg_reg[pfs_pkg::I_OV];
   wire oc_c   = m.iout > cfg_reg[pfs_pkg::I_OC];
   wire ocw_c  = m.iout > cfg_reg[pfs_pkg::I_OCW];
   wire ot_c   = m.temp > otl;
   wire ot_rec = m.temp < ot_thr;
   wire vuv_c  = m.vin < cfg_reg[pfs_pkg::I_VINUV];
   wire vov_c  = m.vin > cfg_reg[pfs_pkg::I_VINOV];
   wire vst_c  = m.vin > cfg_reg[pfs_pkg::I_VINON] && !vov_c;
   wire pg_win = (m.vout >= nom - tol) && (m.vout <= nom + tol);

   // input hysteresis between start threshold and undervoltage
   logic vin_ok_reg;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         vin_ok_reg <= 1'b0;
      else if (vuv_c || vov_c)
         vin_ok_reg <= 1'b0;
      else if (vst_c)
         vin_ok_reg <= 1'b1;
   end

   // control pin qualification
   logic pin_acc_reg;
   logic pin_busy_reg;
   wire  pin_done;
   wire  pin_diff  = pin_s2_reg != pin_acc_reg;
   wire  pin_start = pin_diff && !pin_busy_reg;

   pfs_ms_timer #(
      .MS_CYCLES (MS_CYCLES)
   ) u_pin_tmr (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .start   (pin_start),
      .ms      (pfs_pkg::PIN_MS),
      .done    (pin_done)
   );

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_acc_reg  <= 1'b1;
         pin_busy_reg <= 1'b0;
      end else begin
         if (pin_start)
            pin_busy_reg <= 1'b1;
         else if (pin_done)
            pin_busy_reg <= 1'b0;
         if (pin_done && pin_diff)
            pin_acc_reg <= pin_s2_reg;
      end
   end

   wire [15:0] pri  = cfg_reg[pfs_pkg::I_PRI];
   wire [15:0] sec  = cfg_reg[pfs_pkg::I_ONOFF];
   wire pin_req = pri[pfs_pkg::PRI_IGNORE]
                || !(pin_acc_reg ^ pri[pfs_pkg::PRI_POS]);
   wire sec_req = !sec[pfs_pkg::SEC_USE] || sec[pfs_pkg::SEC_ON];
   wire op_req  = cfg_reg[pfs_pkg::I_OPER][pfs_pkg::OPER_ON];
   wire en_req  = pin_req && sec_req && op_req;
   wire stop    = !en_req || !vin_ok_reg;
   wire ov_latch = cfg_reg[pfs_pkg::I_OVRSP][pfs_pkg::OVRSP_LATCH];

   // sequencer
   pfs_pkg::pfs_state_e st_reg;
   pfs_pkg::pfs_state_e st_next;
   logic [15:0]         status_reg;
   logic [15:0]         tmr_ms;
   wire                 tmr_done;
   wire                 tmr_start = st_next != st_reg;
   wire                 run = st_reg == pfs_pkg::S_RAMP
                           || st_reg == pfs_pkg::S_ON;

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         pfs_pkg::S_INIT: st_next = pfs_pkg::S_BOOT;
         pfs_pkg::S_BOOT:
            if (tmr_done) st_next = pfs_pkg::S_OFF;
         pfs_pkg::S_OFF:
            if (!stop && !ov_c && !ot_c) st_next = pfs_pkg::S_TON;
         pfs_pkg::S_TON:
            if (stop) st_next = pfs_pkg::S_OFF;
            else if (tmr_done) st_next = pfs_pkg::S_RAMP;
         pfs_pkg::S_RAMP, pfs_pkg::S_ON:
            if (ov_c) st_next = pfs_pkg::S_OVW;
            else if (ot_c) st_next = pfs_pkg::S_OT;
            else if (oc_c) st_next = pfs_pkg::S_HIC;
            else if (stop) st_next = pfs_pkg::S_OFF;
            else if (st_reg == pfs_pkg::S_RAMP && tmr_done)
               st_next = pfs_pkg::S_ON;
         pfs_pkg::S_OVW:
            // latched response holds off until the flag is cleared
            if (!ov_c && !(ov_latch && status_reg[pfs_pkg::ST_VOUT_OV]))
               st_next = pfs_pkg::S_OFF;
         pfs_pkg::S_HIC:
            if (tmr_done) st_next = pfs_pkg::S_OFF;
         pfs_pkg::S_OT:
            if (ot_rec) st_next = pfs_pkg::S_OFF;
         default: st_next = pfs_pkg::S_INIT;
      endcase
   end

   always_comb begin
      case (st_next)
         pfs_pkg::S_BOOT: tmr_ms = pfs_pkg::BOOT_MS;
         pfs_pkg::S_TON:  tmr_ms = cfg_reg[pfs_pkg::I_TON];
         pfs_pkg::S_RAMP: tmr_ms = cfg_reg[pfs_pkg::I_TRISE];
         pfs_pkg::S_HIC:  tmr_ms = pfs_pkg::HICCUP_MS;
         default:         tmr_ms = 16'h0000;
      endcase
   end

   // one shared counter times boot, turn-on, ramp and hiccup
   pfs_ms_timer #(
      .MS_CYCLES (MS_CYCLES)
   ) u_seq_tmr (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .start   (tmr_start),
      .ms      (tmr_ms),
      .done    (tmr_done)
   );

   // status word: sticky bits, write one to clear
   wire pg_next = st_next == pfs_pkg::S_ON && pg_win && !ov_c
                && !oc_c && !ot_c && !stop;
   wire [pfs_pkg::NSTICKY-1:0] ev = {
      st_reg == pfs_pkg::S_ON && !pg_win,
      ot_c, vov_c, vuv_c && vin_ok_reg, ocw_c, oc_c, ov_c};
   wire clr_all = wr_cmd && cmd.code == pfs_pkg::CLR_CODE;
   wire clr_w1c = wr_cmd && cmd.code == pfs_pkg::STATUS_CODE;
   wire [15:0] clr_mask = clr_all ? 16'hFFFF
                        : clr_w1c ? cmd.wdata : 16'h0000;
   // a live cause sets again over the clear
   wire [15:0] status_next = (status_reg & ~clr_mask)
                           | {9'h000, ev};

   logic pg_reg;
   logic alert_n_reg;
   logic good_pin_reg;
   logic reg_en_reg;
   logic soft_reg;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg       <= pfs_pkg::S_INIT;
         status_reg   <= 16'h0000;
         pg_reg       <= 1'b0;
         alert_n_reg  <= 1'b1;
         good_pin_reg <= 1'b1;
         reg_en_reg   <= 1'b0;
         soft_reg     <= 1'b0;
      end else begin
         st_reg      <= st_next;
         status_reg  <= status_next;
         pg_reg      <= pg_next;
         alert_n_reg <= ~|status_reg;
         good_pin_reg <= cfg_reg[pfs_pkg::I_PGPOL][0] ? pg_next
                                                     : !pg_next;
         reg_en_reg  <= st_next == pfs_pkg::S_RAMP
                     || st_next == pfs_pkg::S_ON;
         soft_reg    <= st_next == pfs_pkg::S_RAMP;
      end
   end

   // read path
   wire [15:0] live = (16'h0001 << pfs_pkg::ST_IN_REG) & {16{pg_reg}}
                    | (16'h0001 << pfs_pkg::ST_OFF) & {16{!run}};
   logic [15:0] cfg_rd;
   always_comb begin
      cfg_rd = 16'h0000;
      for (int i = 0; i < pfs_pkg::NCFG; i++)
         cfg_rd = cfg_rd | rd_cfg[i];
   end
   wire st_hit = cmd.code == pfs_pkg::STATUS_CODE;
   wire [15:0] rd_val = st_hit ? (status_reg | live)
                      : (|rd_hit) ? cfg_rd : 16'h0000;

   logic        rsp_v_reg;
   logic [15:0] rsp_d_reg;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_v_reg <= 1'b0;
         rsp_d_reg <= 16'h0000;
      end else begin
         rsp_v_reg <= rd_cmd;
         if (rd_cmd)
            rsp_d_reg <= rd_val;
      end
   end

   assign rsp_valid        = rsp_v_reg;
   assign rsp_rdata        = rsp_d_reg;
   assign alert_n          = alert_n_reg;
   assign good_pin         = good_pin_reg;
   assign regulate_en      = reg_en_reg;
   assign softstart_active = soft_reg;

   // checks
   sequence s_ramp_end;
      $fell(soft_reg) ##0 reg_en_reg;
   endsequence
   sequence s_boot;
      st_reg == pfs_pkg::S_BOOT;
   endsequence

   property p_alert_low;
      @(posedge ref_clk) disable iff (!reset_n)
      (|status_reg) |=> !alert_n_reg;
   endproperty
   a_alert_low: assert property (p_alert_low)
      else $error("alert not low with flag set");

   property p_alert_high;
      @(posedge ref_clk) disable iff (!reset_n)
      !(|status_reg) |=> alert_n_reg;
   endproperty
   a_alert_high: assert property (p_alert_high)
      else $error("alert low with no flag");

   property p_alert_follow;
      @(posedge ref_clk) disable iff (!reset_n)
      // only a first flag can make the alert fall
      ($rose(status_reg[pfs_pkg::ST_OTEMP])
         && $past(status_reg) == 16'h0000) |=> $fell(alert_n_reg);
   endproperty
   a_alert_follow: assert property (p_alert_follow)
      else $error("alert missed a new fault");

   property p_oc_cap;
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_reg[pfs_pkg::I_OC] <= pfs_pkg::OC_MAX;
   endproperty
   a_oc_cap: assert property (p_oc_cap)
      else $error("current limit above cap");

   property p_ov_shut;
      @(posedge ref_clk) disable iff (!reset_n)
      (run && ov_c) |=> !reg_en_reg ##0 st_reg == pfs_pkg::S_OVW;
   endproperty
   a_ov_shut: assert property (p_ov_shut)
      else $error("no shutdown on overvoltage");

   property p_ot_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      (st_reg == pfs_pkg::S_OT && !ot_rec) |=> st_reg == pfs_pkg::S_OT;
   endproperty
   a_ot_hold: assert property (p_ot_hold)
      else $error("left overtemperature too early");

   property p_pg;
      @(posedge ref_clk) disable iff (!reset_n)
      pg_reg |-> $past(pg_win) && st_reg == pfs_pkg::S_ON;
   endproperty
   a_pg: assert property (p_pg)
      else $error("good flag outside tolerance");

   property p_pol;
      @(posedge ref_clk) disable iff (!reset_n)
      // pin was registered with the polarity of the previous cycle
      (pg_reg && !$past(cfg_reg[pfs_pkg::I_PGPOL][0])) |-> !good_pin_reg;
   endproperty
   a_pol: assert property (p_pol)
      else $error("good pin polarity wrong");

   property p_enable;
      @(posedge ref_clk) disable iff (!reset_n)
      reg_en_reg |-> $past(en_req) && $past(vin_ok_reg);
   endproperty
   a_enable: assert property (p_enable)
      else $error("output on without all requests");

   property p_boot;
      @(posedge ref_clk) disable iff (!reset_n)
      s_boot |-> !reg_en_reg;
   endproperty
   a_boot: assert property (p_boot)
      else $error("output on during boot");

   property p_ramp;
      @(posedge ref_clk) disable iff (!reset_n)
      s_ramp_end |-> $past(tmr_done);
   endproperty
   a_ramp: assert property (p_ramp)
      else $error("ramp ended before its time");

endmodule

/* File: test/pfs_host_model.sv */
// Purpose: management bus host that issues commands to the supervisor
// Assumes: one command in flight, read answer one cycle after taking
// Notes:   idle command fields carry inverted last values
module pfs_host_model (
   input  wire logic         ref_clk,
   output pfs_pkg::pfs_cmd_s cmd,
   input  wire logic         rsp_valid,
   input  wire logic [15:0]  rsp_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial cmd = '0;

   task automatic send(input logic w, input logic [7:0] c,
                       input logic [15:0] d);
      @(posedge ref_clk);
      cmd <= '{1'b1, w, c, d};
      @(posedge ref_clk);
      cmd <= '{1'b0, ~w, ~c, ~d};
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      send(1'b1, c, d);
   endtask

   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      send(1'b0, c, 16'h0000);
      #1;
      d = (rsp_valid === 1'b1) ? rsp_rdata : 16'hXXXX;
   endtask

   // alert release is the host's move
   task automatic clear_faults;
      send(1'b1, 8'h03, 16'h0000);
   endtask
endmodule

/* File: test/pfs_testbench.sv */
// Purpose: self-checking bench of the power module fault supervisor
// Assumes: MS_CYCLES of 4, so one millisecond is four clocks
// Notes:   waits carry slack for the pin and sensor synchronisers
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 4;
   localparam logic [7:0]  RCODE [9] = '{8'h40, 8'h46, 8'h4A, 8'h4F,
      8'h55, 8'h59, 8'h60, 8'hEA, 8'h99};
   localparam logic [15:0] RRST [9] = '{16'h3999, 16'h0280, 16'h0200,
      16'h007D, 16'h0050, 16'h0020, 16'h0000, 16'h000A, 16'h0000};
   logic               ref_clk = 1'b0;
   logic               reset_n = 1'b0;
   logic               on_off_pin = 1'b0;
   pfs_pkg::pfs_cmd_s  cmd;
   pfs_pkg::pfs_meas_s meas = '{16'h3000, 16'h0100, 16'h0030, 16'h0040};
   logic               rsp_valid;
   logic [15:0]        rsp_rdata;
   logic               alert_n;
   logic               good_pin;
   logic               regulate_en;
   logic               softstart_active;
   logic [3:0]         outs;
   int                 mismatches = 0;
   int                 compares = 0;
   int                 cycles = 0;

   assign outs = {alert_n, good_pin, regulate_en, softstart_active};
   always #20 ref_clk = ~ref_clk;

   pfs_supervisor #(.MS_CYCLES(MS)) i_pfs_supervisor (
      .ref_clk          (ref_clk),
      .reset_n          (reset_n),
      .cmd              (cmd),
      .meas_raw         (meas),
      .on_off_pin       (on_off_pin),
      .rsp_valid        (rsp_valid),
      .rsp_rdata        (rsp_rdata),
      .alert_n          (alert_n),
      .good_pin         (good_pin),
      .regulate_en      (regulate_en),
      .softstart_active (softstart_active)
   );

   pfs_host_model i_pfs_host_model (
      .ref_clk   (ref_clk),
      .cmd       (cmd),
      .rsp_valid (rsp_valid),
      .rsp_rdata (rsp_rdata)
   );

   task automatic give_verdict;
      if (mismatches == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // cut a hang short well past the longest expected run
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 12000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return regulate_en;
         1: return softstart_active;
         2: return good_pin;
         default: return alert_n;
      endcase
   endfunction

   // signal s must reach v, not before lo cycles, not after hi
   task automatic await(input int s, input logic v, input int lo,
                        input int hi);
      int n;
      n = 0;
      #1;
      while (pick(s) !== v && n < hi) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check(16'(pick(s) === v && n >= lo), 16'h0001);
   endtask

   task automatic stay(input int s, input logic v, input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         ok &= (pick(s) === v);
      end
      check(16'(ok), 16'h0001);
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      i_pfs_host_model.wr(c, d);
   endtask

   task automatic rd_chk(input logic [7:0] c, input logic [15:0] m,
                         input logic [15:0] e);
      logic [15:0] v;
      i_pfs_host_model.rd(c, v);
      check(v & m, e);
   endtask

   task automatic recover;
      await(1, 1'b0, 0, 130);
      i_pfs_host_model.clear_faults();
      await(3, 1'b1, 0, 8);
   endtask

   task automatic ov_trip(input logic latch);
      wr(8'h41, {15'h0000, latch});
      @(posedge ref_clk);
      meas.vout <= 16'h3A00;
      await(0, 1'b0, 0, 8);
      await(3, 1'b0, 0, 8);
      i_pfs_host_model.clear_faults();
      stay(3, 1'b0, 10);
      @(posedge ref_clk);
      meas.vout <= 16'h3000;
      stay(3, 1'b0, 10);
      if (latch) begin
         stay(0, 1'b0, 30);
         i_pfs_host_model.clear_faults();
      end
      await(0, 1'b1, 0, 50);
      recover();
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      #1;
      check(16'(outs), 16'h000C);
      await(0, 1'b1, 200*MS - 10, 200*MS + 60);
      check(16'(softstart_active), 16'h0001);
      await(1, 1'b0, 30*MS - 5, 30*MS + 10);
      await(2, 1'b0, 0, 6);
      rd_chk(8'h79, 16'h087F, 16'h0800);
      check(16'(alert_n), 16'h0001);
      foreach (RCODE[i])
         rd_chk(RCODE[i], 16'hFFFF, RRST[i]);
      wr(8'h46, 16'h0321);
      rd_chk(8'h46, 16'hFFFF, 16'h0280);
      wr(8'h46, 16'h0320);
      rd_chk(8'h46, 16'hFFFF, 16'h0320);
      wr(8'h46, 16'h0280);
      wr(8'hD0, 16'h0001);
      await(2, 1'b1, 0, 6);
      wr(8'hD0, 16'h0000);
      await(2, 1'b0, 0, 6);
      ov_trip(1'b1);
      ov_trip(1'b0);
      @(posedge ref_clk);
      meas.temp <= 16'h0080;
      await(0, 1'b0, 0, 8);
      rd_chk(8'h79, 16'h0820, 16'h0020);
      @(posedge ref_clk);
      meas.temp <= 16'h0075;
      stay(0, 1'b0, 40);
      @(posedge ref_clk);
      meas.temp <= 16'h0070;
      await(0, 1'b1, 0, 50);
      recover();
      @(posedge ref_clk);
      meas.iout <= 16'h0300;
      await(0, 1'b0, 0, 8);
      await(0, 1'b1, 100*MS - 10, 100*MS + 30);
      await(0, 1'b0, 0, 8);
      @(posedge ref_clk);
      meas.iout <= 16'h0100;
      await(0, 1'b1, 100*MS - 10, 100*MS + 30);
      recover();
      @(posedge ref_clk);
      meas.vin <= 16'h0010;
      await(0, 1'b0, 0, 8);
      @(posedge ref_clk);
      meas.vin <= 16'h0021;
      stay(0, 1'b0, 40);
      @(posedge ref_clk);
      meas.vin <= 16'h0030;
      await(0, 1'b1, 0, 50);
      recover();
      wr(8'h55, 16'h002C);
      await(0, 1'b0, 0, 8);
      wr(8'h55, 16'h0050);
      await(0, 1'b1, 0, 50);
      recover();
      wr(8'h60, 16'h0005);
      wr(8'h61, 16'h000A);
      wr(8'h01, 16'h0000);
      await(0, 1'b0, 0, 4);
      wr(8'h02, 16'h0001);
      wr(8'h01, 16'h0080);
      stay(0, 1'b0, 30);
      wr(8'h02, 16'h0003);
      await(0, 1'b1, 5*MS - 2, 5*MS + 10);
      await(1, 1'b0, 10*MS - 3, 10*MS + 8);
      @(posedge ref_clk);
      on_off_pin <= 1'b1;
      stay(0, 1'b1, 150*MS);
      await(0, 1'b0, 0, 60*MS);
      give_verdict();
   end
endmodule
